// ==== logic/tmc_pkg.sv ====
// Shared constants and types for the backplane monitor and command/indication handler.
package tmc_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_MON_CTRL = 8'h00;
  localparam logic [7:0] OFS_GLB_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_TXB0 = 8'h0C;
  localparam logic [7:0] OFS_TXB1 = 8'h10;
  localparam logic [7:0] OFS_RXB0 = 8'h14;
  localparam logic [7:0] OFS_RXB1 = 8'h18;
  localparam logic [7:0] OFS_CI0_RX = 8'h1C;
  localparam logic [7:0] OFS_CI0_TX = 8'h20;
  localparam logic [7:0] OFS_CI1_RX = 8'h24;
  localparam logic [7:0] OFS_CI1_TX = 8'h28;
  localparam logic [7:0] OFS_PORT_CFG = 8'h2C;
  // Monitor control field positions: per channel tx control at 2*ch, rx control at 2*ch+1.
  localparam int MONITOR_CONTROL_REG_MIE_BIT = 4;
  // Interrupt status layout: channel ch uses bits 4*ch+3..4*ch.
  localparam int IRQ_RECEIVED = 0;
  localparam int IRQ_END = 1;
  localparam int IRQ_ACKED = 2;
  localparam int IRQ_ABORT = 3;
  localparam int IRQ_CI0 = 8;
  localparam int IRQ_CI1 = 9;
  localparam int IRQ_W = 10;
  // Reset values.
  localparam logic [4:0] MONITOR_CONTROL_REG_RST = 5'h00;
  localparam logic [3:0] CI0_TX_RST = 4'hF;
  localparam logic [5:0] CI1_TX_RST = 6'h3F;
  localparam logic [7:0] TXB_RST = 8'hFF;
  // Frame layout: channels of four bytes, monitor in byte 2, control byte in byte 3.
  localparam logic [6:0] FRAME_BITS_TERM = 7'h60;
  localparam logic [6:0] FRAME_BITS_NTERM = 7'h20;
  localparam logic [1:0] MON_POS = 2'h2;
  localparam logic [1:0] CTL_POS = 2'h3;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // Transmit side handshake states.
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_GAP = 3'b100
  } tmc_tx_state_t;
endpackage

// ==== logic/tmc_mon_chan.sv ====
// One monitor channel: transmit and receive handshake, stepped once per frame.
`timescale 1ns/100ps
`default_nettype none
module tmc_mon_chan
  import tmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame boundary and sampled slot contents
  input wire logic frame_tick,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_mr,
  input wire logic rx_mx,
  // Software controls
  input wire logic ctrl_tx,
  input wire logic ctrl_rx,
  input wire logic wr_pulse,
  input wire logic rd_pulse,
  // Results
  output logic tx_mx,
  output logic tx_mr,
  output logic tx_busy,
  output logic active,
  output logic [7:0] rx_byte,
  output logic [3:0] evt
);
  import tmc_pkg::*;

  tmc_tx_state_t state_reg, state_next;
  logic mx_reg, mx_next, mr_reg, mr_next;
  logic pending_reg, pending_next, seen_ack_reg, seen_ack_next;
  logic wr_flag_reg, wr_flag_next, rd_done_reg, rd_done_next;
  logic prev_mr_reg, prev_mr_next, prev_mx_reg, prev_mx_next;
  logic rx_seen_reg, rx_seen_next, unacked_reg, unacked_next;
  logic first_done_reg, first_done_next;
  logic [7:0] rx_byte_reg, rx_byte_next;
  logic [3:0] evt_reg, evt_next;

  // Nothing here counts time: TX_IDLE and TX_SEND wait for software as long as it takes; TX_GAP lasts one frame.
  always_comb
  begin
    state_next = state_reg;
    pending_next = pending_reg;
    seen_ack_next = seen_ack_reg;
    wr_flag_next = wr_flag_reg;
    rd_done_next = rd_done_reg;
    prev_mr_next = prev_mr_reg;
    prev_mx_next = prev_mx_reg;
    rx_seen_next = rx_seen_reg;
    unacked_next = unacked_reg;
    first_done_next = first_done_reg;
    rx_byte_next = rx_byte_reg;
    mr_next = mr_reg;
    evt_next = 4'h0;
    if (frame_tick)
    begin
      prev_mr_next = rx_mr;
      prev_mx_next = rx_mx;
      case (state_reg)
        TX_IDLE:
          if (ctrl_tx)
          begin
            state_next = TX_SEND;
            pending_next = 1'b1;
            seen_ack_next = 1'b0;
            wr_flag_next = 1'b0;
          end
        TX_SEND:
          if (!ctrl_tx)
            state_next = TX_IDLE;
          else if (pending_reg && prev_mr_reg && !rx_mr)
          begin
            pending_next = 1'b0;
            seen_ack_next = 1'b1;
            evt_next[IRQ_ACKED] = 1'b1;
          end
          else if (seen_ack_reg && prev_mr_reg && rx_mr)
          begin
            seen_ack_next = 1'b0;
            pending_next = 1'b0;
            evt_next[IRQ_ABORT] = 1'b1;
          end
          else if (!pending_reg && wr_flag_reg)
          begin
            state_next = TX_GAP;
            wr_flag_next = 1'b0;
          end
        TX_GAP:
        begin
          state_next = ctrl_tx ? TX_SEND : TX_IDLE;
          pending_next = 1'b1;
        end
        default:
          state_next = TX_IDLE;
      endcase
      if (!rx_mx && prev_mx_reg)
      begin
        rx_byte_next = rx_byte_in;
        evt_next[IRQ_RECEIVED] = 1'b1;
        unacked_next = 1'b1;
        rd_done_next = 1'b0;
        rx_seen_next = 1'b1;
      end
      else if (rx_mx && prev_mx_reg && rx_seen_reg)
      begin
        evt_next[IRQ_END] = 1'b1;
        rx_seen_next = 1'b0;
      end
      if (!ctrl_rx)
      begin
        mr_next = 1'b1;
        first_done_next = 1'b0;
      end
      else if (mr_reg && unacked_reg && (rd_done_reg || !first_done_reg))
      begin
        mr_next = 1'b0;
        unacked_next = 1'b0;
        first_done_next = 1'b1;
      end
      else if (!mr_reg && unacked_reg && rd_done_reg)
        mr_next = 1'b1;
    end
    // Software strobes come last so a strobe in a tick cycle is never lost.
    if (wr_pulse)
      wr_flag_next = 1'b1;
    if (rd_pulse)
      rd_done_next = 1'b1;
    mx_next = (state_next == TX_SEND) ? 1'b0 : 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= TX_IDLE;
      mx_reg <= 1'b1;
      mr_reg <= 1'b1;
      pending_reg <= 1'b0;
      seen_ack_reg <= 1'b0;
      wr_flag_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      prev_mr_reg <= 1'b1;
      prev_mx_reg <= 1'b1;
      rx_seen_reg <= 1'b0;
      unacked_reg <= 1'b0;
      first_done_reg <= 1'b0;
      rx_byte_reg <= IDLE_BYTE;
      evt_reg <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      mx_reg <= mx_next;
      mr_reg <= mr_next;
      pending_reg <= pending_next;
      seen_ack_reg <= seen_ack_next;
      wr_flag_reg <= wr_flag_next;
      rd_done_reg <= rd_done_next;
      prev_mr_reg <= prev_mr_next;
      prev_mx_reg <= prev_mx_next;
      rx_seen_reg <= rx_seen_next;
      unacked_reg <= unacked_next;
      first_done_reg <= first_done_next;
      rx_byte_reg <= rx_byte_next;
      evt_reg <= evt_next;
    end
  end

  assign tx_mx = mx_reg;
  assign tx_mr = mr_reg;
  assign tx_busy = (state_reg != TX_IDLE);
  assign active = tx_busy | rx_seen_reg | ~mr_reg;
  assign rx_byte = rx_byte_reg;
  assign evt = evt_reg;

  a_mx_forced_idle: assert property (@(posedge clk) disable iff (!rst_n)
    frame_tick && !ctrl_tx |=> tx_mx) else $error("mx not idle after tx control cleared");
  a_mr_forced_idle: assert property (@(posedge clk) disable iff (!rst_n)
    frame_tick && !ctrl_rx |=> tx_mr)
    else $error("mr not idle after rx control cleared");
  a_byte_latched: assert property (@(posedge clk) disable iff (!rst_n)
    frame_tick && !rx_mx && prev_mx_reg |=> evt[IRQ_RECEIVED] && rx_byte == $past(rx_byte_in))
    else $error("monitor byte not latched");
  a_ack_raised: assert property (@(posedge clk) disable iff (!rst_n)
    frame_tick && state_reg == TX_SEND && ctrl_tx && pending_reg && prev_mr_reg && !rx_mr
    |=> evt[IRQ_ACKED] && !tx_mx) else $error("acknowledge not reported");
  a_gap_one_frame: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == TX_GAP && frame_tick |=> state_reg != TX_GAP) else $error("gap longer than a frame");
  a_frame_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !frame_tick |=> $stable(tx_mx) && $stable(tx_mr)) else $error("handshake moved between frames");
  c_byte_acked: cover property (@(posedge clk) disable iff (!rst_n) evt[IRQ_ACKED]);
  c_aborted: cover property (@(posedge clk) disable iff (!rst_n) evt[IRQ_ABORT]);
endmodule
`default_nettype wire

// ==== logic/tmc_handler.sv ====
// Backplane monitor and command/indication handler with APB register access.
// Behaviour
// - Two monitor channels terminal, one otherwise.
// - Resend pending monitor byte every frame.
// - Control bit zero forces handshake bit idle.
// - Active status shows transfer in progress.
// - Tx control set drives tx handshake low.
// - Receiver latches byte, flags byte received.
// - Rx control set acknowledges first byte.
// - Next byte: tx handshake idle one frame.
// - After read, rx handshake idle one frame.
// - No timeout anywhere in the handshake.
// - Two idle tx frames signal end.
// - Rx control cleared ends transfer, inactive.
// - Two idle rx frames abort the transmitter.
// - Four-bit code channel 0, two registers.
// - Channel 0 drive may need arbitration grant.
// - Code 0 accepted after two equal frames.
// - Transmit code 0 every frame continuously.
// - Six-bit code channel 1, terminal only.
// - Code 1 change reported immediately.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tmc_handler
  import tmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Backplane link
  input wire logic DCL,
  input wire logic FSC,
  input wire logic RXD,
  input wire logic ARB_GRANT,
  output logic TXD_O,
  output logic TXD_OE
);
  import tmc_pkg::*;

  logic dcl_s1_reg, dcl_s2_reg, dcl_q_reg, fsc_s1_reg, fsc_s2_reg;
  logic rxd_s1_reg, rxd_s2_reg, grant_s1_reg, grant_s2_reg;
  logic dcl_rise, dcl_fall;
  logic fsc_prev_reg, fsc_prev_next, tick_reg, tick_next;
  logic txd_reg, txd_next, txd_oe_reg, txd_oe_next;
  logic [6:0] bit_cnt_reg, bit_cnt_next, idx, last_bit;
  logic [6:0] shift_reg, shift_next;
  logic [7:0] mon_cap_reg [2];
  logic [7:0] mon_cap_next [2];
  logic [7:0] ctl_cap_reg [2];
  logic [7:0] ctl_cap_next [2];
  logic [7:0] mon_out [2];
  logic [7:0] ctl_out [2];
  logic [7:0] sel_byte, in_byte;
  logic [3:0] byte_idx;
  logic drive;
  logic [4:0] monitor_control_reg_reg, monitor_control_reg_next;
  logic cfg_reg, cfg_next;
  logic [3:0] ci0_tx_reg, ci0_tx_next, ci0_rx_reg, ci0_rx_next, ci0_prev_reg, ci0_prev_next;
  logic [5:0] ci1_tx_reg, ci1_tx_next, ci1_rx_reg, ci1_rx_next;
  logic [3:0] ci0_code, ci0_send;
  logic [5:0] ci1_code;
  logic ci0_evt, ci1_evt;
  logic [7:0] txb_reg [2];
  logic [7:0] txb_next [2];
  logic [IRQ_W-1:0] irq_reg, irq_next, irq_set, irq_clr;
  logic [31:0] prdata_reg, prdata_next, rd_data;
  logic setup, access, hit, is_irq_read;
  logic [1:0] wr_pulse, rd_pulse, tx_busy, active;
  logic [7:0] rx_byte [2];
  logic [3:0] evt [2];
  logic [1:0] tx_mx, tx_mr;

  // Every backplane link input crosses two flip-flops; edges are found on the second stage only.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dcl_s1_reg <= 1'b0;
      dcl_s2_reg <= 1'b0;
      dcl_q_reg <= 1'b0;
      fsc_s1_reg <= 1'b0;
      fsc_s2_reg <= 1'b0;
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      grant_s1_reg <= 1'b0;
      grant_s2_reg <= 1'b0;
    end
    else
    begin
      dcl_s1_reg <= DCL;
      dcl_s2_reg <= dcl_s1_reg;
      dcl_q_reg <= dcl_s2_reg;
      fsc_s1_reg <= FSC;
      fsc_s2_reg <= fsc_s1_reg;
      rxd_s1_reg <= RXD;
      rxd_s2_reg <= rxd_s1_reg;
      grant_s1_reg <= ARB_GRANT;
      grant_s2_reg <= grant_s1_reg;
    end
  end
  assign dcl_rise = dcl_s2_reg & ~dcl_q_reg;
  assign dcl_fall = ~dcl_s2_reg & dcl_q_reg;
  assign last_bit = (cfg_reg ? FRAME_BITS_NTERM : FRAME_BITS_TERM) - 7'h01;

  // Channel 0 code is driven only while the arbitration grant allows it in terminal timing.
  assign ci0_send = (cfg_reg || grant_s2_reg) ? ci0_tx_reg : 4'hF;
  assign ci0_code = ctl_cap_reg[0][5:2];
  assign ci1_code = ctl_cap_reg[1][7:2];

  // Bits are driven after the data clock rises and sampled when it falls.
  always_comb
  begin
    fsc_prev_next = fsc_prev_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    mon_cap_next = mon_cap_reg;
    ctl_cap_next = ctl_cap_reg;
    tick_next = 1'b0;
    txd_next = txd_reg;
    txd_oe_next = txd_oe_reg;
    idx = bit_cnt_reg;
    sel_byte = IDLE_BYTE;
    drive = 1'b0;
    in_byte = {shift_reg, rxd_s2_reg};
    if (dcl_rise)
    begin
      fsc_prev_next = fsc_s2_reg;
      idx = (fsc_s2_reg && !fsc_prev_reg) ? 7'h00 : bit_cnt_reg + 7'h01;
      bit_cnt_next = idx;
    end
    byte_idx = idx[6:3];
    if (byte_idx[3:2] == 2'h0 || (byte_idx[3:2] == 2'h1 && !cfg_reg))
    begin
      if (byte_idx[1:0] == MON_POS)
      begin
        sel_byte = mon_out[byte_idx[2]];
        drive = 1'b1;
      end
      else if (byte_idx[1:0] == CTL_POS)
      begin
        sel_byte = ctl_out[byte_idx[2]];
        drive = 1'b1;
      end
    end
    if (dcl_rise)
    begin
      txd_next = sel_byte[3'h7 - idx[2:0]];
      txd_oe_next = drive & ~sel_byte[3'h7 - idx[2:0]];
    end
    if (dcl_fall)
    begin
      shift_next = in_byte[6:0];
      if (idx[2:0] == 3'h7 && drive)
      begin
        if (byte_idx[1:0] == MON_POS)
          mon_cap_next[byte_idx[2]] = in_byte;
        else
          ctl_cap_next[byte_idx[2]] = in_byte;
      end
      if (bit_cnt_reg == last_bit)
        tick_next = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fsc_prev_reg <= 1'b0;
      bit_cnt_reg <= 7'h7F;
      shift_reg <= 7'h7F;
      mon_cap_reg <= '{IDLE_BYTE, IDLE_BYTE};
      ctl_cap_reg <= '{IDLE_BYTE, IDLE_BYTE};
      tick_reg <= 1'b0;
      txd_reg <= 1'b1;
      txd_oe_reg <= 1'b0;
    end
    else
    begin
      fsc_prev_reg <= fsc_prev_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      mon_cap_reg <= mon_cap_next;
      ctl_cap_reg <= ctl_cap_next;
      tick_reg <= tick_next;
      txd_reg <= txd_next;
      txd_oe_reg <= txd_oe_next;
    end
  end

  // Channel 1 is held idle in non-terminal timing so it raises nothing.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      logic en;
      assign en = (g == 0) || !cfg_reg;
      tmc_mon_chan u_chan (
        .clk(CLK),
        .rst_n(RST_N),
        .frame_tick(tick_reg),
        .rx_byte_in(mon_cap_reg[g]),
        .rx_mr(ctl_cap_reg[g][1] | ~en),
        .rx_mx(ctl_cap_reg[g][0] | ~en),
        .ctrl_tx(monitor_control_reg_reg[2*g] & en),
        .ctrl_rx(monitor_control_reg_reg[2*g+1] & en),
        .wr_pulse(wr_pulse[g]),
        .rd_pulse(rd_pulse[g]),
        .tx_mx(tx_mx[g]),
        .tx_mr(tx_mr[g]),
        .tx_busy(tx_busy[g]),
        .active(active[g]),
        .rx_byte(rx_byte[g]),
        .evt(evt[g])
      );
      assign mon_out[g] = tx_busy[g] ? txb_reg[g] : IDLE_BYTE;
      assign irq_set[4*g+3:4*g] = evt[g] & {{3{monitor_control_reg_reg[MONITOR_CONTROL_REG_MIE_BIT]}}, 1'b1};
    end
  endgenerate
  assign ctl_out[0] = {2'h3, ci0_send, tx_mr[0], tx_mx[0]};
  assign ctl_out[1] = {ci1_tx_reg, tx_mr[1], tx_mx[1]};

  // Code 0 needs two equal frames; code 1 is taken as soon as it changes.
  always_comb
  begin
    ci0_prev_next = ci0_prev_reg;
    ci0_rx_next = ci0_rx_reg;
    ci1_rx_next = ci1_rx_reg;
    ci0_evt = 1'b0;
    ci1_evt = 1'b0;
    if (tick_reg)
    begin
      ci0_prev_next = ci0_code;
      if (ci0_code == ci0_prev_reg && ci0_code != ci0_rx_reg)
      begin
        ci0_rx_next = ci0_code;
        ci0_evt = 1'b1;
      end
      if (!cfg_reg && ci1_code != ci1_rx_reg)
      begin
        ci1_rx_next = ci1_code;
        ci1_evt = 1'b1;
      end
    end
  end
  assign irq_set[IRQ_CI0] = ci0_evt;
  assign irq_set[IRQ_CI1] = ci1_evt;

  // Zero-wait APB slave; read data is captured in the setup cycle.
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  always_comb
  begin
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (PADDR == OFS_MON_CTRL)
      rd_data[4:0] = monitor_control_reg_reg;
    else if (PADDR == OFS_GLB_STAT)
      rd_data[1:0] = active;
    else if (PADDR == OFS_IRQ_STAT)
      rd_data[IRQ_W-1:0] = irq_reg;
    else if (PADDR == OFS_TXB0)
      rd_data[7:0] = txb_reg[0];
    else if (PADDR == OFS_TXB1)
      rd_data[7:0] = txb_reg[1];
    else if (PADDR == OFS_RXB0)
      rd_data[7:0] = rx_byte[0];
    else if (PADDR == OFS_RXB1)
      rd_data[7:0] = rx_byte[1];
    else if (PADDR == OFS_CI0_RX)
      rd_data[3:0] = ci0_rx_reg;
    else if (PADDR == OFS_CI0_TX)
      rd_data[3:0] = ci0_tx_reg;
    else if (PADDR == OFS_CI1_RX)
      rd_data[5:0] = ci1_rx_reg;
    else if (PADDR == OFS_CI1_TX)
      rd_data[5:0] = ci1_tx_reg;
    else if (PADDR == OFS_PORT_CFG)
      rd_data[0] = cfg_reg;
    else
      hit = 1'b0;
  end

  always_comb
  begin
    monitor_control_reg_next = monitor_control_reg_reg;
    cfg_next = cfg_reg;
    ci0_tx_next = ci0_tx_reg;
    ci1_tx_next = ci1_tx_reg;
    txb_next = txb_reg;
    wr_pulse = 2'h0;
    rd_pulse = 2'h0;
    prdata_next = setup ? rd_data : prdata_reg;
    is_irq_read = access && !PWRITE && PADDR == OFS_IRQ_STAT;
    if (access && PWRITE)
    begin
      if (PADDR == OFS_MON_CTRL)
        monitor_control_reg_next = PWDATA[4:0];
      else if (PADDR == OFS_TXB0)
      begin
        txb_next[0] = PWDATA[7:0];
        wr_pulse[0] = 1'b1;
      end
      else if (PADDR == OFS_TXB1)
      begin
        txb_next[1] = PWDATA[7:0];
        wr_pulse[1] = 1'b1;
      end
      else if (PADDR == OFS_CI0_TX)
        ci0_tx_next = PWDATA[3:0];
      else if (PADDR == OFS_CI1_TX)
        ci1_tx_next = PWDATA[5:0];
      else if (PADDR == OFS_PORT_CFG)
        cfg_next = PWDATA[0];
    end
    if (access && !PWRITE && PADDR == OFS_RXB0)
      rd_pulse[0] = 1'b1;
    if (access && !PWRITE && PADDR == OFS_RXB1)
      rd_pulse[1] = 1'b1;
    // Only bits that were reported are cleared, and a new event wins over the clear.
    irq_clr = is_irq_read ? prdata_reg[IRQ_W-1:0] : '0;
    irq_next = (irq_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      monitor_control_reg_reg <= MONITOR_CONTROL_REG_RST;
      cfg_reg <= 1'b0;
      ci0_tx_reg <= CI0_TX_RST;
      ci1_tx_reg <= CI1_TX_RST;
      ci0_rx_reg <= CI0_TX_RST;
      ci0_prev_reg <= CI0_TX_RST;
      ci1_rx_reg <= CI1_TX_RST;
      txb_reg <= '{TXB_RST, TXB_RST};
      irq_reg <= '0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      monitor_control_reg_reg <= monitor_control_reg_next;
      cfg_reg <= cfg_next;
      ci0_tx_reg <= ci0_tx_next;
      ci1_tx_reg <= ci1_tx_next;
      ci0_rx_reg <= ci0_rx_next;
      ci0_prev_reg <= ci0_prev_next;
      ci1_rx_reg <= ci1_rx_next;
      txb_reg <= txb_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~hit;
  assign TXD_O = txd_reg;
  assign TXD_OE = txd_oe_reg;

  a_ci0_double_look: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_reg && ci0_code == ci0_prev_reg && ci0_code != ci0_rx_reg
    |=> ci0_rx_reg == $past(ci0_code) && irq_reg[IRQ_CI0]) else $error("code 0 not accepted");
  a_ci0_single_frame: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_reg && ci0_code != ci0_prev_reg |=> $stable(ci0_rx_reg)) else $error("code 0 taken early");
  a_ci1_direct: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_reg && !cfg_reg && ci1_code != ci1_rx_reg |=> ci1_rx_reg == $past(ci1_code))
    else $error("code 1 change missed");
  a_irq_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    !is_irq_read |=> (irq_reg & $past(irq_reg)) == $past(irq_reg)) else $error("status lost");
  a_ch1_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_reg && cfg_reg |=> !tx_busy[1] && tx_mr[1] && tx_mx[1])
    else $error("channel 1 busy off terminal");
  c_ci0_change: cover property (@(posedge CLK) disable iff (!RST_N) ci0_evt);
  c_msg_received: cover property (@(posedge CLK) disable iff (!RST_N) irq_reg[IRQ_RECEIVED]);
endmodule
`default_nettype wire

// ==== tb/tmc_far_end.sv ====
// Far-end backplane device: link clock, frame sync, slot bytes out, handler's bytes captured.
`timescale 1ns/100ps
`default_nettype none
module tmc_far_end
(
  // Link timing and data towards the handler
  output logic dcl,
  output logic fsc,
  output logic rxd,
  // Open-drain data from the handler
  input wire logic txd_o,
  input wire logic txd_oe
);
  logic [7:0] tx_bytes [0:11];
  logic [7:0] rx_bytes [0:11];
  logic [7:0] shift = 8'h00;
  int frames = 0;
  initial
  begin
    dcl = 1'b0;
    foreach (tx_bytes[i])
      tx_bytes[i] = 8'hFF;
    forever
    begin
      for (int b = 0; b < 96; b++)
      begin
        fsc = (b == 0);
        #80 dcl = 1'b1;
        rxd = tx_bytes[b / 8][7 - b % 8];
        #160 dcl = 1'b0;
        // The line has a pull-up, so a released driver reads as one.
        shift = {shift[6:0], (txd_oe ? txd_o : 1'b1)};
        if (b % 8 == 7)
          rx_bytes[b / 8] = shift;
        #80;
      end
      frames++;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the backplane monitor and command/indication handler.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb;
  import tmc_pkg::*;
  logic clk, dcl, fsc, rxd, txd_o, txd_oe, pready, pslverr, eq;
  logic rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arb = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  int err_count = 0, checks_done = 0, ones;
  tmc_handler u_tmc_handler (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DCL(dcl), .FSC(fsc), .RXD(rxd), .ARB_GRANT(arb), .TXD_O(txd_o),
    .TXD_OE(txd_oe));
  tmc_far_end u_far (.dcl(dcl), .fsc(fsc), .rxd(rxd), .txd_o(txd_o), .txd_oe(txd_oe));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic stop_hung();
    err_count++;
    tally_and_finish();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) stop_hung();
    q = prdata;
    eq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Frames are counted by the far end, so the wait is bounded in clock cycles.
  task automatic wf(input int k);
    int t, n;
    t = u_far.frames + k;
    n = 0;
    while (u_far.frames < t && n++ < 1000 * k)
      @(posedge clk);
    if (n > 1000 * k) stop_hung();
    repeat (4) @(posedge clk);
  endtask
  task automatic watch(input int bi, input int bn);
    ones = 0;
    repeat (4)
    begin
      wf(1);
      ones += u_far.rx_bytes[bi][bn];
    end
  endtask
  task automatic t_regs();
    apb(0, OFS_CI0_TX, 0);
    `CHK(q, 32'h0000_000F)
    apb(0, OFS_CI1_TX, 0);
    `CHK(q, 32'h0000_003F)
    apb(0, 8'h30, 0);
    `CHK({eq, q}, {1'b1, 32'h0000_0000})
    `CHK(u_far.rx_bytes[2], IDLE_BYTE)
    `CHK(u_far.rx_bytes[3], IDLE_BYTE)
    apb(0, OFS_IRQ_STAT, 0);
    $display("test regs done");
  endtask
  task automatic t_ci();
    apb(1, OFS_CI0_TX, 32'h0000_0005);
    apb(1, OFS_CI1_TX, 32'h0000_002A);
    wf(2);
    `CHK(u_far.rx_bytes[3], 8'hD7)
    `CHK(u_far.rx_bytes[7], 8'hAB)
    arb <= 1'b0;
    wf(2);
    `CHK(u_far.rx_bytes[3], 8'hFF)
    arb <= 1'b1;
    u_far.tx_bytes[3] = 8'hE7;
    wf(1);
    u_far.tx_bytes[3] = 8'hFF;
    wf(2);
    apb(0, OFS_CI0_RX, 0);
    `CHK(q, 32'h0000_000F)
    u_far.tx_bytes[3] = 8'hE7;
    u_far.tx_bytes[7] = 8'h57;
    wf(1);
    apb(0, OFS_CI1_RX, 0);
    `CHK(q, 32'h0000_0015)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q[IRQ_CI1:IRQ_CI0], 2'b10)
    wf(1);
    apb(0, OFS_CI0_RX, 0);
    `CHK(q, 32'h0000_0009)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q[IRQ_CI1:IRQ_CI0], 2'b01)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q, 32'h0000_0000)
    u_far.tx_bytes[3] = 8'hFF;
    u_far.tx_bytes[7] = 8'hFF;
    wf(3);
    apb(0, OFS_IRQ_STAT, 0);
    $display("test cmdind done");
  endtask
  task automatic t_mtx();
    apb(1, OFS_TXB0, 32'h0000_00A5);
    apb(1, OFS_MON_CTRL, 32'h0000_0011);
    wf(2);
    `CHK(u_far.rx_bytes[3][0], 1'b0)
    apb(0, OFS_GLB_STAT, 0);
    `CHK(q[0], 1'b1)
    wf(3);
    `CHK(u_far.rx_bytes[2], 8'hA5)
    u_far.tx_bytes[3] = 8'hFD;
    wf(2);
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q[IRQ_ACKED], 1'b1)
    apb(1, OFS_TXB0, 32'h0000_003C);
    watch(3, 0);
    `CHK(ones, 1)
    `CHK(u_far.rx_bytes[2], 8'h3C)
    u_far.tx_bytes[3] = 8'hFF;
    wf(3);
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q[IRQ_ABORT:IRQ_ACKED], 2'b10)
    apb(1, OFS_MON_CTRL, 32'h0000_0010);
    wf(2);
    `CHK(u_far.rx_bytes[3][0], 1'b1)
    $display("test monitor transmit done");
  endtask
  task automatic t_mrx();
    u_far.tx_bytes[6] = 8'h5A;
    u_far.tx_bytes[7] = 8'hFE;
    wf(2);
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q[4 + IRQ_RECEIVED], 1'b1)
    apb(0, OFS_RXB1, 0);
    `CHK(q, 32'h0000_005A)
    apb(1, OFS_MON_CTRL, 32'h0000_0018);
    wf(2);
    `CHK(u_far.rx_bytes[7][1], 1'b0)
    u_far.tx_bytes[7] = 8'hFF;
    wf(1);
    u_far.tx_bytes[6] = 8'hC3;
    u_far.tx_bytes[7] = 8'hFE;
    wf(3);
    `CHK(u_far.rx_bytes[7][1], 1'b0)
    apb(0, OFS_RXB1, 0);
    `CHK(q, 32'h0000_00C3)
    watch(7, 1);
    `CHK(ones, 1)
    u_far.tx_bytes[7] = 8'hFF;
    wf(3);
    apb(0, OFS_IRQ_STAT, 0);
    `CHK(q[4 + IRQ_END], 1'b1)
    apb(1, OFS_MON_CTRL, 0);
    wf(2);
    `CHK(u_far.rx_bytes[7][1], 1'b1)
    apb(0, OFS_GLB_STAT, 0);
    `CHK(q[1], 1'b0)
    $display("test monitor receive done");
  endtask
  task automatic t_nterm();
    apb(1, OFS_PORT_CFG, 32'h0000_0001);
    apb(0, OFS_PORT_CFG, 0);
    `CHK(q, 32'h0000_0001)
    u_far.tx_bytes[7] = 8'h57;
    wf(2);
    `CHK(u_far.rx_bytes[3], 8'hD7)
    `CHK(u_far.rx_bytes[7], IDLE_BYTE)
    apb(0, OFS_CI1_RX, 0);
    `CHK(q, 32'h0000_003F)
    $display("test non-terminal done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wf(2);
    t_regs();
    t_ci();
    t_mtx();
    t_mrx();
    t_nterm();
    tally_and_finish();
  end
endmodule
`default_nettype wire
